// ===== design/sct_pin_sync.sv
`timescale 1ns/10ps
module sct_pin_sync #(
  parameter int WIDTH = 6
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_q <= '0;
      syncOut <= '0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule // sct_pin_sync

// ===== design/sct_pkg.sv
package sct_pkg;

  localparam int NUM_CH = 6;
  localparam int CNT_W = 16;
  localparam int PRESC_W = 7;

  // register byte addresses, one 32-bit word each
  localparam logic [7:0] ADDR_SC = 8'h00;
  localparam logic [7:0] ADDR_CNT = 8'h04;
  localparam logic [7:0] ADDR_MOD = 8'h08;
  localparam logic [7:0] ADDR_CH_BASE = 8'h10;
  localparam logic [7:0] ADDR_CH_END = 8'h40;
  localparam int CH_IDX_LSB = 3;
  localparam int CH_VAL_BIT = 2;

  // status/control word fields
  localparam int SC_TOF_BIT = 7;
  localparam int SC_TOIE_BIT = 6;
  localparam int SC_STOP_BIT = 5;
  localparam int SC_TRST_BIT = 4;
  localparam int CTL_FLAG_BIT = 7;
  localparam int CTL_LSB = 1;

  localparam logic [2:0] CLKSEL_EXT = 3'h7;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR = 2'h2;
  localparam logic [1:0] ELS_SET = 2'h3;

  localparam logic [CNT_W-1:0] MOD_RESET = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [PRESC_W-1:0] PRESC_RESET = 7'h00;

  typedef struct packed {
    logic ovfFlag;
    logic ovfIe;
    logic stop;
    logic [2:0] clkSel;
  } sct_ctrl_t;

  localparam sct_ctrl_t CTRL_RESET = '{ovfFlag: 1'b0, ovfIe: 1'b0,
                                       stop: 1'b1, clkSel: 3'h0};

  // channel status/control, bits 7..1 of its word
  typedef struct packed {
    logic flag;
    logic ie;
    logic modeB;
    logic modeA;
    logic edgeB;
    logic edgeA;
    logic ovfToggle;
  } sct_chctl_t;

  localparam sct_chctl_t CHCTL_RESET = '0;

endpackage

// ===== design/sct_timer.sv
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
// Function
// - three-bit select: seven bus rates or pin 0
// - one shared 16-bit modulo counter for channels
// - capture copies counter on selected pin edge
// - capture overwrites value even if flag set
// - event sets flag; interrupt only when enabled
// - capture value registers have no reset
// - compare match sets, clears or toggles pin
// - unbuffered compare uses current register value
// - link bit 0 pairs channels 0/1 on pin 0
// - last written pair register controls after overflow
// - linked odd control unused, its pin released
// - same pairing for channels 2/3 and 4/5
// - toggle on overflow; modulo sets PWM period
// - edge select A picks clear or set on compare
// - select 000 counts every bus clock
// - mode 01 unbuffered, 10 buffered compare
// - link bit overrides the other mode bit
// - no overflow toggle with clear on compare gives 0% duty cycle
module sct_timer
  import sct_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_CH-1:0] pinIn,
  output logic [NUM_CH-1:0] pinOut,
  output logic [NUM_CH-1:0] pinOe,
  output logic [NUM_CH-1:0] chanIrq,
  output logic ovfIrq
);

  localparam int NUM_PAIR = NUM_CH / 2;

  function automatic logic [PRESC_W-1:0] divMask(input logic [2:0] sel);
    logic [PRESC_W:0] one;
    one = '0;
    one[sel] = 1'b1;
    divMask = PRESC_W'(one - 1'b1);
  endfunction

  // a low-byte-only write completes the pair from the held high byte
  function automatic logic [CNT_W-1:0] merge16(input logic [7:0] hi,
                                                input logic [31:0] d,
                                                input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : hi, d[7:0]};
  endfunction

  sct_ctrl_t ctrl_q;
  sct_chctl_t ctl_q [NUM_CH];
  logic [CNT_W-1:0] chVal_q [NUM_CH];
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] mod_q;
  logic [PRESC_W-1:0] presc_q;
  logic [7:0] highBuf_q;
  logic cntNew_q;
  logic ovfEv_q;
  logic [NUM_CH-1:0] pinPrev_q;
  logic [NUM_PAIR-1:0] active_q;
  logic [NUM_PAIR-1:0] lastWr_q;
  logic [NUM_CH-1:0] pinSync;

  sct_pin_sync #(.WIDTH(NUM_CH)) uSync (
    .core_clk(core_clk),
    .rst(rst),
    .asyncIn(pinIn),
    .syncOut(pinSync)
  );

  wire logic [NUM_CH-1:0] riseEv = pinSync & ~pinPrev_q;
  wire logic [NUM_CH-1:0] fallEv = ~pinSync & pinPrev_q;

  // bus decode
  wire logic accessPh = psel & penable;
  wire logic inChRange = (paddr >= ADDR_CH_BASE) && (paddr < ADDR_CH_END);
  wire logic [7:0] chOfs = paddr - ADDR_CH_BASE;
  wire logic [2:0] chSel = chOfs[CH_IDX_LSB+2:CH_IDX_LSB];
  wire logic chIsVal = chOfs[CH_VAL_BIT];
  wire logic scSel = paddr == ADDR_SC;
  wire logic cntSel = paddr == ADDR_CNT;
  wire logic modSel = paddr == ADDR_MOD;
  wire logic addrOk = (paddr[1:0] == 2'h0)
                      && (scSel || cntSel || modSel || inChRange);
  wire logic wrEn = accessPh & pwrite & pready & addrOk;
  wire logic lowWr = wrEn & pstrb[0];
  wire logic hiOnlyWr = wrEn & pstrb[1] & ~pstrb[0];
  wire logic scWr = lowWr & scSel;
  wire logic modWr = lowWr & modSel;
  wire logic trstPulse = scWr & pwdata[SC_TRST_BIT];
  wire logic [NUM_CH-1:0] ctlWr;
  wire logic [NUM_CH-1:0] valWr;

  // count clock
  wire logic [PRESC_W-1:0] mask = divMask(ctrl_q.clkSel);
  wire logic intTick = (presc_q & mask) == mask;
  wire logic tick = (ctrl_q.clkSel == CLKSEL_EXT) ? riseEv[0]
                                                  : intTick;
  wire logic running = tick & ~ctrl_q.stop;
  wire logic atMod = cnt_q == mod_q;
  wire logic wrapNow = running & atMod;

  wire logic [31:0] scRd = {24'h0, ctrl_q.ovfFlag, ctrl_q.ovfIe,
                            ctrl_q.stop, 2'h0, ctrl_q.clkSel};
  wire logic [31:0] chRd = chIsVal ? {16'h0, chVal_q[chSel]}
                                   : {24'h0, ctl_q[chSel], 1'b0};
  wire logic [31:0] rdMux = !addrOk ? 32'h0 :
                            scSel ? scRd :
                            cntSel ? {16'h0, cnt_q} :
                            modSel ? {16'h0, mod_q} : chRd;

  // apb slave: one wait state, answer on second access cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= accessPh & ~pready;
      pslverr <= accessPh & ~pready & ~addrOk;
      if (accessPh & ~pready) begin
        prdata <= pwrite ? 32'h0 : rdMux;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      highBuf_q <= 8'h0;
    end else if (hiOnlyWr) begin
      highBuf_q <= pwdata[15:8];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      if (scWr) begin
        ctrl_q.ovfIe <= pwdata[SC_TOIE_BIT];
        ctrl_q.stop <= pwdata[SC_STOP_BIT];
        ctrl_q.clkSel <= pwdata[2:0];
        ctrl_q.ovfFlag <= ctrl_q.ovfFlag & pwdata[SC_TOF_BIT];
      end
      if (ovfEv_q) begin
        ctrl_q.ovfFlag <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mod_q <= MOD_RESET;
    end else if (modWr) begin
      mod_q <= merge16(highBuf_q, pwdata, pstrb);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || trstPulse) begin
      presc_q <= PRESC_RESET;
    end else if (!ctrl_q.stop) begin
      presc_q <= presc_q + 1'b1;
    end
  end

  // shared time base for every channel
  always_ff @(posedge core_clk) begin
    if (rst || trstPulse) begin
      cnt_q <= CNT_RESET;
      cntNew_q <= 1'b0;
      ovfEv_q <= 1'b0;
    end else begin
      cntNew_q <= running;
      ovfEv_q <= wrapNow;
      if (running) begin
        cnt_q <= atMod ? CNT_RESET : cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pinPrev_q <= '0;
      ovfIrq <= 1'b0;
    end else begin
      pinPrev_q <= pinSync;
      ovfIrq <= ctrl_q.ovfFlag & ctrl_q.ovfIe;
    end
  end

  // pair select follows the last written register at each overflow
  for (genvar p = 0; p < NUM_PAIR; p++) begin : gPair
    always_ff @(posedge core_clk) begin
      if (rst || !ctl_q[2*p].modeB) begin
        active_q[p] <= 1'b0;
        lastWr_q[p] <= 1'b0;
      end else begin
        if (valWr[2*p]) begin
          lastWr_q[p] <= 1'b0;
        end
        if (valWr[2*p+1]) begin
          lastWr_q[p] <= 1'b1;
        end
        if (wrapNow) begin
          active_q[p] <= lastWr_q[p];
        end
      end
    end
  end

  for (genvar c = 0; c < NUM_CH; c++) begin : gCh
    localparam int EV = c - (c % 2);
    localparam int P = c / 2;
    localparam bit ODD = (c % 2) == 1;

    wire logic slave = ODD && ctl_q[EV].modeB;
    wire logic linked = !ODD && ctl_q[c].modeB;
    wire logic isCap = !slave && !ctl_q[c].modeB && !ctl_q[c].modeA;
    wire logic isCmp = !slave && (ctl_q[c].modeB || ctl_q[c].modeA);
    wire logic [1:0] els = {ctl_q[c].edgeB, ctl_q[c].edgeA};
    wire logic drive = isCmp && (els != 2'h0);
    wire logic [CNT_W-1:0] cmpVal = (linked && active_q[P]) ? chVal_q[EV+1]
                                                            : chVal_q[c];
    wire logic capEv = isCap && ((ctl_q[c].edgeA && riseEv[c])
                              || (ctl_q[c].edgeB && fallEv[c]));
    wire logic cmpEv = isCmp && cntNew_q && (cnt_q == cmpVal);
    wire logic ovfTog = ovfEv_q && ctl_q[c].ovfToggle;
    wire logic togPin = ovfTog ? ~pinOut[c] : pinOut[c];
    wire sct_chctl_t ctlIn = sct_chctl_t'(pwdata[CTL_FLAG_BIT:CTL_LSB]);

    assign ctlWr[c] = lowWr && inChRange && !chIsVal && (chSel == 3'(c));
    assign valWr[c] = lowWr && inChRange && chIsVal && (chSel == 3'(c));

    always_ff @(posedge core_clk) begin
      if (rst) begin
        ctl_q[c] <= CHCTL_RESET;
      end else begin
        if (ctlWr[c] && !slave) begin
          ctl_q[c] <= ctlIn;
          // link bit exists on even channels only; it wins over mode A
          ctl_q[c].modeB <= !ODD && ctlIn.modeB;
          ctl_q[c].flag <= ctl_q[c].flag & ctlIn.flag;
        end
        if (capEv || cmpEv) begin
          ctl_q[c].flag <= 1'b1;
        end
      end
    end

    // no reset: captured time survives reset
    always_ff @(posedge core_clk) begin
      if (capEv) begin
        chVal_q[c] <= cnt_q;
      end else if (valWr[c]) begin
        chVal_q[c] <= merge16(highBuf_q, pwdata, pstrb);
      end
    end

    always_ff @(posedge core_clk) begin
      if (rst) begin
        pinOut[c] <= 1'b0;
        pinOe[c] <= 1'b0;
        chanIrq[c] <= 1'b0;
      end else begin
        pinOe[c] <= drive;
        chanIrq[c] <= ctl_q[c].flag & ctl_q[c].ie;
        if (!drive) begin
          pinOut[c] <= 1'b0;
        end else if (cmpEv) begin
          case (els)
            ELS_TOGGLE: pinOut[c] <= ~togPin;
            ELS_CLEAR: pinOut[c] <= 1'b0;
            ELS_SET: pinOut[c] <= 1'b1;
            default: pinOut[c] <= togPin;
          endcase
        end else begin
          pinOut[c] <= togPin;
        end
      end
    end
  end

endmodule // sct_timer

// ===== testbench/sct_pin_model.sv
`timescale 1ns/10ps
module sct_pin_model (
  input wire logic [5:0] lvl,
  output logic [5:0] pinIn
);
  // pull-down idle; edges land off the clock edge, as a real pin would
  initial pinIn = 6'h00;
  always @(lvl) pinIn <= #3 lvl;
endmodule // sct_pin_model

// ===== testbench/sct_timer_assertions.sv
`timescale 1ns/10ps
module sct_timer_assertions
  import sct_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_CH-1:0] pinIn,
  input wire logic [NUM_CH-1:0] pinOut,
  input wire logic [NUM_CH-1:0] pinOe,
  input wire logic [NUM_CH-1:0] chanIrq,
  input wire logic ovfIrq
);
  wire wrDone = pready && pwrite;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_wait: assert property (psel && !penable |-> ##2 pready)
    else $error("pready not in second access cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == '0)
    else $error("refused read returned data");
  a_out_released: assert property ((pinOut & ~pinOe) == '0)
    else $error("pin level while not driving");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> !pready && pinOe == '0 && chanIrq == '0 && !ovfIrq)
    else $error("outputs active after reset");
  a_oe_written: assert property ($changed(pinOe)
    |-> $past(wrDone) || $past(wrDone, 2))
    else $error("pin enable changed without a write");
  c_err: cover property (pslverr);
  c_oe: cover property (pinOe[0] && !pinOe[1]);
  c_irq: cover property (chanIrq[1]);
endmodule // sct_timer_assertions

bind sct_timer sct_timer_assertions u_sct_timer_assertions (.core_clk,
  .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .pready, .pslverr, .pinIn, .pinOut, .pinOe, .chanIrq, .ovfIrq);

// ===== testbench/sct_timer_tb.sv
`timescale 1ns/10ps
module sct_timer_tb
  import sct_pkg::*;
;
  logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, ovfIrq, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, v;
  logic [3:0] pstrb = 4'h3;
  logic [NUM_CH-1:0] pinIn, pinOut, pinOe, chanIrq, lvl = 6'h00;
  int failures = 0, checked = 0, seed = 32'hFC473C4F, cyc = 0;
  int hi, lo, t, g;
  int expq[$];

  sct_timer u_sct_timer (.core_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .pinIn, .pinOut, .pinOe,
    .chanIrq, .ovfIrq);
  sct_pin_model u_sct_pin_model (.lvl, .pinIn);

  initial begin
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;

  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] y);
    checked++;
    if (y !== x) begin
      failures++;
      $display("BAD %s exp %h got %h", n, x, y);
    end
  endtask

  // idle edge first, so a strobe is never reassigned in one step
  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // look between edges; only the bench watchdog ends a hang here
    do begin
      @(negedge core_clk);
    end while (pready !== 1'b1);
    @(posedge core_clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic lv(input int c, input logic b, output int n);
    n = 0;
    while (pinOut[c] !== b && n < 3000) begin
      n++;
      @(negedge core_clk);
    end
  endtask

  task automatic meas(input int c);
    lv(c, 1'b0, t);
    lv(c, 1'b1, t);
    lv(c, 1'b0, hi);
    lv(c, 1'b1, lo);
  endtask

  task automatic results;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rw(1'b0, ADDR_SC, 32'h0);
    chk("ctrl", 32'h20, r);
    rw(1'b0, ADDR_MOD, 32'h0);
    chk("mod", 32'hFFFF, r);
    rw(1'b0, ADDR_CNT, 32'h0);
    chk("cnt", 32'h0, r);
    rw(1'b0, 8'h0C, 32'h0);
    chk("err", 32'h1, e);
    $display("test regs done");
    rw(1'b1, ADDR_MOD, 32'hFF);
    rw(1'b1, 8'h18, 32'h44);
    rw(1'b1, ADDR_SC, 32'h0);
    g = 40 + ($random(seed) & 127);
    lvl[1] <= 1'b1;
    t = cyc;
    repeat (8) @(posedge core_clk);
    rw(1'b0, 8'h1C, 32'h0);
    v = r;
    chk("irq", 32'h1, chanIrq[1]);
    lvl[1] <= 1'b0;
    while (cyc < t + g) @(posedge core_clk);
    lvl[1] <= 1'b1;
    repeat (8) @(posedge core_clk);
    rw(1'b0, 8'h1C, 32'h0);
    expq.push_back(g);
    chk("capgap", expq.pop_front(), (r - v) & 32'hFF);
    rw(1'b0, 8'h18, 32'h0);
    chk("chflag", 32'hC4, r);
    $display("test capture done");
    rw(1'b1, 8'h14, 32'h80);
    rw(1'b1, 8'h10, 32'h1A);
    for (int k = 0; k < 2; k++) begin
      rw(1'b1, ADDR_SC, k);
      meas(0);
      chk("high", 128 << k, hi);
      chk("period", 256 << k, hi + lo);
    end
    chk("oe", 32'h1, pinOe[0]);
    rw(1'b1, 8'h10, 32'h18);
    repeat (600) @(posedge core_clk);
    chk("zero", 32'h0, pinOut[0]);
    $display("test pwm done");
    rw(1'b1, ADDR_SC, 32'h40);
    rw(1'b1, 8'h18, 32'h1A);
    rw(1'b1, 8'h10, 32'h3A);
    rw(1'b1, 8'h1C, 32'h40);
    meas(0);
    meas(0);
    chk("bufhigh", 32'h40, hi);
    chk("gpio", 32'h0, pinOe[1]);
    chk("ovfirq", 32'h1, ovfIrq);
    rw(1'b0, 8'h10, 32'h0);
    chk("cmpflag", 32'hBA, r);
    $display("test buffered done");
    results;
  end

  // whole run needs about 3200 cycles
  initial begin
    repeat (30000) @(posedge core_clk);
    failures++;
    results;
  end
endmodule // sct_timer_tb
